//--- verilog/dsli_pkg.sv
// package of constants for the dac serial load interface
package dsli_pkg;
    localparam int DSLI_SHIFT_W = 24;
    localparam int DSLI_CODE_W = 16;
    localparam int DSLI_CHANNELS = 4;
    localparam int DSLI_CHAN_W = 2;
    // frame layout: low two bits of the top byte pick a channel, low word is the code
    localparam int DSLI_CODE_LSB = 0;
    localparam int DSLI_CHAN_LSB = 16;
    localparam logic [15:0] DSLI_ZERO_CODE = 16'h0000;
    localparam logic [15:0] DSLI_MID_CODE = 16'h8000;
    localparam logic [23:0] DSLI_SHIFT_RST = 24'h000000;
    localparam logic [1:0] DSLI_SYNC_RST = 2'h0;
    localparam logic [1:0] DSLI_SYNC_IDLE = 2'h3;
    // serial clock ceiling in MHz; unused, and too fast for the 40 MHz sampling of the link clock
    localparam int DSLI_SCLK_MAX_MHZ = 25;
    localparam int DSLI_MCLK_MHZ = 40;
endpackage : dsli_pkg

//--- verilog/dsli_top.sv
// serial load interface of a four channel converter
`timescale 1ns/1ps
module dsli_top
    import dsli_pkg::*;
(
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_RESET,
    // serial link
    input wire logic I_SCLK,
    input wire logic I_FRAME_SEL_N,
    input wire logic I_SERIAL_IN,
    output logic O_SERIAL_OUT,
    output logic O_SERIAL_OUT_OE_N,
    // control pins
    input wire logic I_LOAD_STROBE_N,
    input wire logic I_CLEAR_IN,
    // outside configuration: 1 selects mid code on clear
    input wire logic I_CLEAR_MID_SEL,
    // converter codes
    output logic [DSLI_CHANNELS*DSLI_CODE_W-1:0] O_CHAN_CODES
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    // the link clock is sampled; 40 MHz only resolves slow serial clocks,
    // so the host must keep each phase longer than two system cycles
    logic [1:0] sclk_sync_q;
    logic [1:0] sel_sync_q;
    logic [1:0] sdi_sync_q;
    logic [1:0] ld_sync_q;
    logic [1:0] clr_sync_q;
    logic [1:0] mid_sync_q;
    logic sclk_prev_q;

    // link pins share one depth so data stays aligned with its clock
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            sclk_sync_q <= DSLI_SYNC_RST;
            sel_sync_q <= DSLI_SYNC_IDLE;
            sdi_sync_q <= DSLI_SYNC_RST;
        end else begin
            sclk_sync_q <= {sclk_sync_q[0], I_SCLK};
            sel_sync_q <= {sel_sync_q[0], I_FRAME_SEL_N};
            sdi_sync_q <= {sdi_sync_q[0], I_SERIAL_IN};
        end
    end

    // control pins pass the same two stages as the link pins
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            ld_sync_q <= DSLI_SYNC_IDLE;
            clr_sync_q <= DSLI_SYNC_RST;
            mid_sync_q <= DSLI_SYNC_RST;
        end else begin
            ld_sync_q <= {ld_sync_q[0], I_LOAD_STROBE_N};
            clr_sync_q <= {clr_sync_q[0], I_CLEAR_IN};
            mid_sync_q <= {mid_sync_q[0], I_CLEAR_MID_SEL};
        end
    end

    // ------------------------------------------------------------
    // serial clock edge detect
    // ------------------------------------------------------------
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            sclk_prev_q <= DSLI_SYNC_RST[0];
        end else begin
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    logic sclk_fall;
    logic frame_on;
    logic shift_en;
    logic sdi_bit;
    assign sclk_fall = sclk_prev_q & ~sclk_sync_q[1];
    assign frame_on = ~sel_sync_q[1];
    assign shift_en = frame_on & sclk_fall;
    assign sdi_bit = sdi_sync_q[1];

    // ------------------------------------------------------------
    // input shift register
    // ------------------------------------------------------------
    logic [DSLI_SHIFT_W-1:0] shift_q;
    logic [DSLI_SHIFT_W-1:0] shift_d;
    logic [DSLI_SHIFT_W-2:0] shift_keep;
    assign shift_keep = shift_q[DSLI_SHIFT_W-2:0];

    always_comb begin
        shift_d = shift_q;
        if (shift_en) begin
            shift_d = {shift_keep, sdi_bit};
        end
    end

    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            shift_q <= DSLI_SHIFT_RST;
        end else begin
            shift_q <= shift_d;
        end
    end

    // ------------------------------------------------------------
    // serial output
    // ------------------------------------------------------------
    // the msb is shifted out; it changes right after a falling edge, so
    // the next bit is stable well before the following falling edge
    logic sdo_q;
    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            sdo_q <= DSLI_SHIFT_RST[DSLI_SHIFT_W-1];
        end else begin
            sdo_q <= shift_d[DSLI_SHIFT_W-1];
        end
    end
    assign O_SERIAL_OUT = sdo_q;
    assign O_SERIAL_OUT_OE_N = ~frame_on;

    // ------------------------------------------------------------
    // converter registers and clear
    // ------------------------------------------------------------
    logic [DSLI_CODE_W-1:0] chan_q [DSLI_CHANNELS];
    logic [DSLI_CHAN_W-1:0] load_chan;
    logic [DSLI_CODE_W-1:0] load_code;
    logic [DSLI_CODE_W-1:0] clr_code;
    assign load_chan = shift_q[DSLI_CHAN_LSB +: DSLI_CHAN_W];
    assign load_code = shift_q[DSLI_CODE_LSB +: DSLI_CODE_W];
    assign clr_code = mid_sync_q[1] ? DSLI_MID_CODE : DSLI_ZERO_CODE;

    always_ff @(posedge I_MCLK or posedge I_RESET) begin
        if (I_RESET) begin
            for (int i = 0; i < DSLI_CHANNELS; i++) begin
                chan_q[i] <= DSLI_ZERO_CODE;
            end
        end else if (clr_sync_q[1]) begin
            // clear dominates a load held at the same time
            for (int i = 0; i < DSLI_CHANNELS; i++) begin
                chan_q[i] <= clr_code;
            end
        end else if (!ld_sync_q[1]) begin
            chan_q[load_chan] <= load_code;
        end
    end

    always_comb begin
        for (int i = 0; i < DSLI_CHANNELS; i++) begin
            O_CHAN_CODES[i*DSLI_CODE_W +: DSLI_CODE_W] = chan_q[i];
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // pins reach the logic two cycles late, so the checks watch the
    // synchronised copies and name the pin only where the lag is the point
    // link side
    a_shift_on_fall: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        shift_en |=> shift_q == {$past(shift_keep), $past(sdi_bit)})
        else $error("shift register missed a falling edge");
    a_no_stray_shift: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        !$past(shift_en) |-> $stable(shift_q))
        else $error("shift register moved without a falling edge");
    a_hold_unselected: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        !frame_on |=> $stable(shift_q))
        else $error("shift register moved while unselected");
    a_sdo_release: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        O_SERIAL_OUT_OE_N == $past(I_FRAME_SEL_N, 2))
        else $error("serial output enable wrong");
    a_sdo_msb: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        sclk_fall |-> ##1 O_SERIAL_OUT == shift_q[DSLI_SHIFT_W-1])
        else $error("serial output not msb after edge");
    a_sdo_steady: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        !$past(shift_en) |-> $stable(O_SERIAL_OUT))
        else $error("serial output moved between falling edges");

    // converter side
    a_load_copy: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        (!ld_sync_q[1] && !clr_sync_q[1]) |=>
        chan_q[$past(load_chan)] == $past(load_code))
        else $error("load did not copy code");
    a_codes_hold: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        (ld_sync_q[1] && !clr_sync_q[1]) |=> $stable(O_CHAN_CODES))
        else $error("codes changed without load or clear");
    a_clear_force: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        clr_sync_q[1] ##1 clr_sync_q[1] |->
        chan_q[0] == $past(clr_code) &&
        chan_q[DSLI_CHANNELS-1] == $past(clr_code))
        else $error("clear did not force channels");
    a_clear_all: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        clr_sync_q[1] |=> O_CHAN_CODES == {DSLI_CHANNELS{$past(clr_code)}})
        else $error("clear missed a channel");
    a_clear_zero: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        (clr_sync_q[1] && !mid_sync_q[1]) |=> chan_q[1] == DSLI_ZERO_CODE)
        else $error("default clear code not zero");
    a_clear_mid: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        (clr_sync_q[1] && mid_sync_q[1]) |=> chan_q[3] == DSLI_MID_CODE)
        else $error("mid clear code not applied");
    a_clear_beats_load: assert property (@(posedge I_MCLK)
        disable iff (I_RESET)
        (clr_sync_q[1] && !ld_sync_q[1]) |=>
        chan_q[2] == $past(clr_code))
        else $error("load overrode clear");
endmodule : dsli_top

//--- verification/dsli_host_model.sv
// host controller model that drives the serial link
`timescale 1ns/1ps
module dsli_host_model (
    // serial link
    output logic o_sclk,
    output logic o_frame_sel_n,
    output logic o_serial_in,
    input wire logic i_serial_out
);
    initial begin
        o_sclk = 1'h1;
        o_frame_sel_n = 1'h1;
        o_serial_in = 1'h0;
    end
    // msb first; 200 ns period keeps well under the ceiling
    task automatic frame(input logic [23:0] w, input logic sel_n,
                         output logic [23:0] rd);
        o_frame_sel_n = sel_n;
        for (int i = 23; i >= 0; i--) begin
            o_serial_in = w[i];
            #100 o_sclk = 1'h0;
            rd[i] = i_serial_out;
            #100 o_sclk = 1'h1;
        end
        #100 o_frame_sel_n = 1'h1;
        // released line flips so a stale bit is never mistaken for data
        o_serial_in = ~w[0];
        // idle gap so the sampled select is seen high between frames
        #100;
    endtask : frame
endmodule : dsli_host_model

//--- verification/dsli_top_tb.sv
// testbench for the converter serial load interface
`timescale 1ns/1ps
module dsli_top_tb;
    import dsli_pkg::*;
    logic mclk = 1'h0, reset = 1'h1, load_n = 1'h1, clear = 1'h0;
    logic mid_sel = 1'h0, sclk, sel_n, sdi, sdo_q, sdo_oe_n;
    wire sdo_w;
    logic [DSLI_CHANNELS*DSLI_CODE_W-1:0] codes;
    logic [23:0] rd;
    int n_mismatch = 0, cmp_count = 0;
    assign sdo_w = sdo_oe_n ? 1'hz : sdo_q;
    always #12.5 mclk = ~mclk;
    dsli_top uut (.I_MCLK(mclk), .I_RESET(reset), .I_SCLK(sclk),
        .I_FRAME_SEL_N(sel_n), .I_SERIAL_IN(sdi), .O_SERIAL_OUT(sdo_q),
        .O_SERIAL_OUT_OE_N(sdo_oe_n), .I_LOAD_STROBE_N(load_n),
        .I_CLEAR_IN(clear), .I_CLEAR_MID_SEL(mid_sel), .O_CHAN_CODES(codes));
    dsli_host_model host (.o_sclk(sclk), .o_frame_sel_n(sel_n),
        .o_serial_in(sdi), .i_serial_out(sdo_w));
    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [63:0] exp,
                         input logic [63:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run
    task automatic t_shift;
        host.frame(24'h03a5c3, 1'h0, rd);
        check("readback after reset", 64'h0, rd);
        host.frame(24'h5a0f1e, 1'h0, rd);
        check("readback", 64'h03a5c3, rd);
        tick(4);
        check("oe_n idle", 64'h1, sdo_oe_n);
    endtask : t_shift
    task automatic t_ignore;
        host.frame(24'hffffff, 1'h1, rd);
        check("released line", {40'h0, 24'hzzzzzz}, rd);
        host.frame(24'h021234, 1'h0, rd);
        check("held register", 64'h5a0f1e, rd);
    endtask : t_ignore
    task automatic t_load;
        check("codes before load", 64'h0, codes);
        load_n = 1'h0;
        tick(3);
        load_n = 1'h1;
        tick(4);
        check("loaded codes", 64'h0000_1234_0000_0000, codes);
    endtask : t_load
    task automatic t_clear;
        clear = 1'h1;
        tick(5);
        check("clear zero", 64'h0, codes);
        mid_sel = 1'h1;
        load_n = 1'h0;
        tick(5);
        check("clear beats load", 64'h8000_8000_8000_8000, codes);
        clear = 1'h0;
        tick(5);
        load_n = 1'h1;
        check("load after clear", 64'h8000_1234_8000_8000, codes);
    endtask : t_clear
    initial begin
        tick(8);
        reset = 1'h0;
        tick(3);
        check("reset codes", 64'h0, codes);
        t_shift();
        t_ignore();
        t_load();
        t_clear();
        complete_run();
    end
    // four frames take about 20 us; allow plenty beyond that
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
endmodule : dsli_top_tb
